// ==== rtl/satellite_supply_ctrl_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module satellite_supply_ctrl_regs (
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    input  wire supply_ctrl_pkg::wr_req_t wr,
    input  wire logic                  rd_en,
    input  wire logic [7:0]            rd_addr,
    output var  logic [7:0]            rd_data,
    input  wire logic                  overload_det,
    input  wire logic                  overheat_det,
    input  wire logic                  tone_input_pin,
    output var  supply_ctrl_pkg::supply_ctl_t ctl,
    output var  logic [7:0]            status0
);
    // -------------------------------------------------------------
    // storage
    // -------------------------------------------------------------
    logic [7:0] output_level_ctrl_r;
    logic [7:0] tone_ctrl_r;
    logic [7:0] current_limit_ctrl_r;
    logic [7:0] fault_recovery_ctrl_r;
    logic [7:0] burst_addr_r;
    logic [7:0] wr_addr;
    logic       overload_flag;
    logic       overheat_flag;
    logic       tone_pin_s;
    logic       overload_latch_off;
    logic       heat_latch_off;
    logic       clear_level;
    logic [7:0] status_nxt;

    // fault and pin inputs come from analogue comparators and a pin
    sync2 #(.W(3)) u_sync (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .d       ({overload_det, overheat_det, tone_input_pin}),
        .q       ({overload_flag, overheat_flag, tone_pin_s})
    );

    assign overload_latch_off = fault_recovery_ctrl_r[supply_ctrl_pkg::OVERLOAD_LATCH_BIT];
    assign heat_latch_off     = fault_recovery_ctrl_r[supply_ctrl_pkg::HEAT_LATCH_BIT];
    // latch-off modes wipe the code; fault beats a same-cycle host write
    assign clear_level = (overload_latch_off && overload_flag)  // R9
                       || (heat_latch_off && overheat_flag);    // R12

    // -------------------------------------------------------------
    // burst address tracking
    // -------------------------------------------------------------
    // first byte uses the given address, later ones the next higher
    assign wr_addr = wr.first ? wr.addr : burst_addr_r; // R17

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            burst_addr_r <= supply_ctrl_pkg::CTRL_RESET;
        end else if (wr.valid) begin
            burst_addr_r <= wr_addr + 8'h01; // R17
        end
    end

    // -------------------------------------------------------------
    // control registers
    // -------------------------------------------------------------
    // output level register, with fault-driven clear
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            output_level_ctrl_r <= supply_ctrl_pkg::CTRL_RESET; // R5
        end else if (clear_level) begin
            output_level_ctrl_r[supply_ctrl_pkg::LEVEL_SEL_LSB +: 4] <= 4'h0; // R9 R12
        end else if (wr.valid && wr_addr == supply_ctrl_pkg::ADDR_OUTPUT_LEVEL) begin
            output_level_ctrl_r <= wr.data; // R1 R3
        end
    end

    // remaining registers store the whole byte, reserved bits included
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            tone_ctrl_r           <= supply_ctrl_pkg::CTRL_RESET; // R5
            current_limit_ctrl_r  <= supply_ctrl_pkg::CTRL_RESET;
            fault_recovery_ctrl_r <= supply_ctrl_pkg::CTRL_RESET;
        end else if (wr.valid) begin
            case (wr_addr) // R1
                supply_ctrl_pkg::ADDR_TONE:          tone_ctrl_r           <= wr.data;
                supply_ctrl_pkg::ADDR_CURRENT_LIMIT: current_limit_ctrl_r  <= wr.data;
                supply_ctrl_pkg::ADDR_FAULT_RECOVER: fault_recovery_ctrl_r <= wr.data;
                default: ;
            endcase
        end
    end

    // -------------------------------------------------------------
    // status and readback
    // -------------------------------------------------------------
    // flags sit at fixed bit positions, the rest read zero
    always_comb begin
        status_nxt = 8'h00;
        status_nxt[supply_ctrl_pkg::OVERLOAD_FLAG_BIT] = overload_flag; // R15
        status_nxt[supply_ctrl_pkg::OVERHEAT_FLAG_BIT] = overheat_flag; // R16
    end

    // status byte leaves through a flop like every other data output
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            status0 <= 8'h00;
        end else begin
            status0 <= status_nxt; // R15 R16
        end
    end

    // registered read data; unmapped addresses read zero
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            case (rd_addr) // R2
                supply_ctrl_pkg::ADDR_STATUS0:       rd_data <= status0;
                supply_ctrl_pkg::ADDR_OUTPUT_LEVEL:  rd_data <= output_level_ctrl_r;
                supply_ctrl_pkg::ADDR_TONE:          rd_data <= tone_ctrl_r;
                supply_ctrl_pkg::ADDR_CURRENT_LIMIT: rd_data <= current_limit_ctrl_r;
                supply_ctrl_pkg::ADDR_FAULT_RECOVER: rd_data <= fault_recovery_ctrl_r;
                default:                             rd_data <= 8'h00;
            endcase
        end
    end

    // -------------------------------------------------------------
    // decoded controls
    // -------------------------------------------------------------
    // output is off while any fault is active; auto mode keeps the code
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctl <= '0;
        end else begin
            ctl.level_sel <=
                output_level_ctrl_r[supply_ctrl_pkg::LEVEL_SEL_LSB +: 4]; // R18 R11 R14
            ctl.output_on <= !overload_flag && !overheat_flag && !clear_level; // R11 R14
            ctl.tone_out  <= tone_ctrl_r[supply_ctrl_pkg::TONE_OUTPUT_ON_BIT] && tone_pin_s; // R6
            ctl.tone_input_source <= tone_ctrl_r[supply_ctrl_pkg::TONE_INPUT_SRC_BIT]; // R7
            ctl.pulsed_limit_off  <=
                current_limit_ctrl_r[supply_ctrl_pkg::PULSED_LIMIT_OFF_BIT]; // R8
        end
    end

    // -------------------------------------------------------------
    // checks: storage and writes
    // -------------------------------------------------------------
    // reset, early or late, leaves all four bytes at zero
    a_reset_clears: assert property (@(posedge ref_clk) // R5
        !rstn |=> (output_level_ctrl_r == supply_ctrl_pkg::CTRL_RESET)
                  && (tone_ctrl_r == supply_ctrl_pkg::CTRL_RESET)
                  && (current_limit_ctrl_r == supply_ctrl_pkg::CTRL_RESET)
                  && (fault_recovery_ctrl_r == supply_ctrl_pkg::CTRL_RESET))
        else $error("control register not cleared by reset");
    // the first byte of a transfer lands at the address it names
    a_tone_write: assert property (@(posedge ref_clk) disable iff (!rstn) // R1
        (wr.valid && wr.first && wr.addr == supply_ctrl_pkg::ADDR_TONE)
            |=> tone_ctrl_r == $past(wr.data))
        else $error("tone register write lost");
    a_recover_write: assert property (@(posedge ref_clk) disable iff (!rstn) // R1
        (wr.valid && wr.first && wr.addr == supply_ctrl_pkg::ADDR_FAULT_RECOVER)
            |=> fault_recovery_ctrl_r == $past(wr.data))
        else $error("recovery register write lost");
    // later bytes reach the next register through the burst address
    a_limit_write: assert property (@(posedge ref_clk) disable iff (!rstn) // R1 R17
        (wr.valid && wr_addr == supply_ctrl_pkg::ADDR_CURRENT_LIMIT)
            |=> current_limit_ctrl_r == $past(wr.data))
        else $error("current limit register write lost");
    a_burst_advance: assert property (@(posedge ref_clk) disable iff (!rstn) // R17
        wr.valid |=> burst_addr_r == $past(wr_addr) + 8'h01)
        else $error("burst address did not advance");
    // a level write only sticks while no latch-off fault stands
    a_level_write: assert property (@(posedge ref_clk) disable iff (!rstn) // R3
        (wr.valid && wr_addr == supply_ctrl_pkg::ADDR_OUTPUT_LEVEL && !clear_level)
            |=> output_level_ctrl_r == $past(wr.data))
        else $error("level register write lost");
    a_auto_keeps_code: assert property (@(posedge ref_clk) disable iff (!rstn) // R11
        (!clear_level && !wr.valid) |=> $stable(output_level_ctrl_r))
        else $error("level code changed without write or latch fault");

    // -------------------------------------------------------------
    // checks: readback and status
    // -------------------------------------------------------------
    // read data is the byte held at the strobe edge
    a_readback_match: assert property (@(posedge ref_clk) disable iff (!rstn) // R2
        (rd_en && rd_addr == supply_ctrl_pkg::ADDR_TONE) |=> rd_data == $past(tone_ctrl_r))
        else $error("readback mismatch");
    a_level_readback: assert property (@(posedge ref_clk) disable iff (!rstn) // R2
        (rd_en && rd_addr == supply_ctrl_pkg::ADDR_OUTPUT_LEVEL)
            |=> rd_data == $past(output_level_ctrl_r))
        else $error("level readback mismatch");
    // the second status byte carries no flags here and reads zero
    a_status1_zero: assert property (@(posedge ref_clk) disable iff (!rstn) // R1
        (rd_en && rd_addr == supply_ctrl_pkg::ADDR_STATUS1)
            |=> rd_data == 8'h00)
        else $error("second status byte not zero");
    // flags land at bits 0 and 6 one edge after the synchroniser
    a_status_flags: assert property (@(posedge ref_clk) disable iff (!rstn) // R15 R16
        ##1 status0 == {1'b0, $past(overheat_flag), 5'b00000, $past(overload_flag)})
        else $error("status byte wrong");

    // -------------------------------------------------------------
    // checks: fault handling
    // -------------------------------------------------------------
    // latch-off wipes the code each cycle the fault stands
    a_latch_clears_code: assert property (@(posedge ref_clk) disable iff (!rstn) // R9 R12
        clear_level |=> output_level_ctrl_r[3:0] == 4'h0)
        else $error("level code not cleared on latch-off fault");
    a_overload_latch: assert property (@(posedge ref_clk) disable iff (!rstn) // R9
        (fault_recovery_ctrl_r[supply_ctrl_pkg::OVERLOAD_LATCH_BIT] && overload_flag)
            |=> (output_level_ctrl_r[3:0] == 4'h0) && !ctl.output_on)
        else $error("overload latch-off did not clear and disable");
    a_heat_latch: assert property (@(posedge ref_clk) disable iff (!rstn) // R12
        (fault_recovery_ctrl_r[supply_ctrl_pkg::HEAT_LATCH_BIT] && overheat_flag)
            |=> (output_level_ctrl_r[3:0] == 4'h0) && !ctl.output_on)
        else $error("heat latch-off did not clear and disable");
    // output follows the flags in both modes, back on once they drop
    a_fault_output_off: assert property (@(posedge ref_clk) disable iff (!rstn) // R9 R12 R14
        (overload_flag || overheat_flag) |=> !ctl.output_on)
        else $error("output on during fault");
    a_auto_recover: assert property (@(posedge ref_clk) disable iff (!rstn) // R11 R14
        (!overload_flag && !overheat_flag) |=> ctl.output_on)
        else $error("output not back on after fault");

    // -------------------------------------------------------------
    // checks: decoded controls
    // -------------------------------------------------------------
    // tone gate and the plain copies of the control bits
    a_tone_gate: assert property (@(posedge ref_clk) disable iff (!rstn) // R6
        !tone_ctrl_r[supply_ctrl_pkg::TONE_OUTPUT_ON_BIT] |=> !ctl.tone_out)
        else $error("tone out while disabled");
    a_tone_follows: assert property (@(posedge ref_clk) disable iff (!rstn) // R6
        (tone_ctrl_r[supply_ctrl_pkg::TONE_OUTPUT_ON_BIT] && tone_pin_s) |=> ctl.tone_out)
        else $error("tone out missing while enabled");
    a_tone_source: assert property (@(posedge ref_clk) disable iff (!rstn) // R7
        ##1 ctl.tone_input_source
            == $past(tone_ctrl_r[supply_ctrl_pkg::TONE_INPUT_SRC_BIT]))
        else $error("tone input source wrong");
    a_limit_follows: assert property (@(posedge ref_clk) disable iff (!rstn) // R8
        ##1 ctl.pulsed_limit_off
            == $past(current_limit_ctrl_r[supply_ctrl_pkg::PULSED_LIMIT_OFF_BIT]))
        else $error("pulsed limit control wrong");
    a_level_passes: assert property (@(posedge ref_clk) disable iff (!rstn) // R18
        ##1 ctl.level_sel
            == $past(output_level_ctrl_r[3:0]))
        else $error("level code not passed on unchanged");
endmodule : satellite_supply_ctrl_regs
`default_nettype wire

// ==== rtl/supply_ctrl_pkg.sv ====
// Overview of operation
// [R1] four read/write registers at addresses 2..5
// [R2] read returns last byte written there
// [R3] level select code in bits 3:0 of 0x2
// [R4] host writes reserved bits as zero
// [R5] all register bits clear at power-on
// [R6] tone output follows pin when enabled
// [R7] tone_ctrl bit 2 selects tone input type
// [R8] current_limit_ctrl bit 2 disables pulsed limiting
// [R9] overload latch-off clears level code, output off
// [R10] host rewrites level code after overload clears
// [R11] overload auto mode re-enables with old code
// [R12] heat latch-off clears level code, output off
// [R13] host rewrites level code after overheat clears
// [R14] heat auto mode re-enables with old code
// [R15] overload flag is status bit 0
// [R16] overheat flag is status bit 6
// [R17] burst writes advance to next register address
// [R18] level code passed to regulator unchanged
`default_nettype none
package supply_ctrl_pkg;

    // -------------------------------------------------------------
    // register map
    // -------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS0       = 8'h00;
    localparam logic [7:0] ADDR_STATUS1       = 8'h01;
    localparam logic [7:0] ADDR_OUTPUT_LEVEL  = 8'h02;
    localparam logic [7:0] ADDR_TONE          = 8'h03;
    localparam logic [7:0] ADDR_CURRENT_LIMIT = 8'h04;
    localparam logic [7:0] ADDR_FAULT_RECOVER = 8'h05;
    localparam logic [7:0] CTRL_RESET         = 8'h00;

    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int LEVEL_SEL_LSB        = 0;
    localparam int TONE_OUTPUT_ON_BIT   = 0;
    localparam int TONE_INPUT_SRC_BIT   = 2;
    localparam int PULSED_LIMIT_OFF_BIT = 2;
    localparam int OVERLOAD_LATCH_BIT   = 3;
    localparam int HEAT_LATCH_BIT       = 6;
    localparam int OVERLOAD_FLAG_BIT    = 0;
    localparam int OVERHEAT_FLAG_BIT    = 6;

    // register write request from the serial front end
    typedef struct packed {
        logic       valid;
        logic       first;
        logic [7:0] addr;
        logic [7:0] data;
    } wr_req_t;

    // decoded controls towards the analogue side
    typedef struct packed {
        logic [3:0] level_sel;
        logic       output_on;
        logic       tone_out;
        logic       tone_input_source;
        logic       pulsed_limit_off;
    } supply_ctl_t;

endpackage : supply_ctrl_pkg
`default_nettype wire

// ==== rtl/sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for asynchronous levels
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // first stage is read only by the second
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : sync2
`default_nettype wire

// ==== test/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// host side: write bursts and register reads, changed 1 ns after an edge
module host_model (
    input  wire logic                     ref_clk,
    input  wire logic [7:0]               rd_data,
    output var  supply_ctrl_pkg::wr_req_t wr,
    output var  logic                     rd_en,
    output var  logic [7:0]               rd_addr
);
    initial begin
        wr = '0;
        rd_en = 1'b0;
        rd_addr = 8'h00;
    end
    // callers pass zero in reserved bits and rewrite codes after faults
    task automatic write_burst(input logic [7:0] start, input logic [31:0] d, input int n);
        for (int k = 0; k < n; k++) begin
            wr = '{valid: 1'b1, first: (k == 0), addr: start, data: d[8*k+:8]};
            @(posedge ref_clk);
            #1;
        end
        wr.valid = 1'b0;
        wr.data = ~wr.data; // stale byte must not look valid
    endtask : write_burst
    // one strobe, answer taken an edge later
    task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
        rd_en = 1'b1;
        rd_addr = a;
        @(posedge ref_clk);
        #1;
        rd_en = 1'b0;
        rd_addr = ~a;
        @(posedge ref_clk);
        #1;
        v = rd_data;
    endtask : read_reg
endmodule : host_model
`default_nettype wire

// ==== test/satellite_supply_ctrl_regs_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module satellite_supply_ctrl_regs_bench;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic overload_det = 1'b0;
    logic overheat_det = 1'b0;
    logic tone_input_pin = 1'b0;
    logic rd_en;
    logic [7:0] rd_addr, rd_data, status0;
    supply_ctrl_pkg::wr_req_t wr;
    supply_ctrl_pkg::supply_ctl_t ctl;
    int err_count = 0;
    int num_checks = 0;
    always #50 ref_clk = ~ref_clk;
    host_model host (.ref_clk(ref_clk), .rd_data(rd_data), .wr(wr), .rd_en(rd_en),
                     .rd_addr(rd_addr));
    satellite_supply_ctrl_regs uut (.ref_clk(ref_clk), .rstn(rstn), .wr(wr), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data), .overload_det(overload_det),
        .overheat_det(overheat_det), .tone_input_pin(tone_input_pin), .ctl(ctl),
        .status0(status0));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host.read_reg(a, v);
        chk("read", exp, v);
    endtask : rd_chk
    task automatic reset_values();
        for (int a = 2; a <= 5; a++) rd_chk(8'(a), 8'h00);
        chk("ctl", {4'h0, 1'b1, 3'b000}, ctl);
        chk("status0", 8'h00, status0);
    endtask : reset_values
    // burst over all four registers, then unmapped places
    task automatic burst_and_map();
        host.write_burst(8'h00, 32'h00035A5A, 3);
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h01, 8'h00);
        rd_chk(8'h02, 8'h03);
        host.write_burst(8'h02, 32'h0004050A, 4);
        step(2);
        for (int k = 0; k < 4; k++) rd_chk(8'(k + 2), 8'(32'h0004050A >> (8 * k)));
        chk("level_sel", 8'h0A, ctl.level_sel);
        chk("tone_src", 8'h01, ctl.tone_input_source);
        chk("pls_off", 8'h01, ctl.pulsed_limit_off);
        host.write_burst(8'h06, 32'h0000005A, 1);
        step(2);
        rd_chk(8'h06, 8'h00);
        rd_chk(8'h01, 8'h00);
    endtask : burst_and_map
    // tone follows the pin only while enabled
    task automatic tone_gate();
        host.write_burst(8'h03, 32'h00000001, 2);
        tone_input_pin = 1'b1;
        step(4);
        chk("tone_out", 8'h01, ctl.tone_out);
        chk("tone_src", 8'h00, ctl.tone_input_source);
        chk("pls_off", 8'h00, ctl.pulsed_limit_off);
        tone_input_pin = 1'b0;
        step(4);
        chk("tone_out", 8'h00, ctl.tone_out);
        host.write_burst(8'h03, 32'h00000000, 1);
        tone_input_pin = 1'b1;
        step(4);
        chk("tone_out", 8'h00, ctl.tone_out);
    endtask : tone_gate
    // one fault source in auto or latch-off recovery
    task automatic fault_case(input bit heat, input bit latch);
        logic [7:0] cfg;
        cfg = latch ? (heat ? 8'h40 : 8'h08) : 8'h00;
        host.write_burst(8'h05, {24'h0, cfg}, 1);
        step(2);
        overheat_det = heat;
        overload_det = !heat;
        step(4);
        chk("status0", heat ? 8'h40 : 8'h01, status0);
        chk("output_on", 8'h00, ctl.output_on);
        chk("level_sel", latch ? 8'h00 : 8'h0A, ctl.level_sel);
        rd_chk(8'h00, heat ? 8'h40 : 8'h01);
        if (latch) begin
            host.write_burst(8'h02, 32'h00000005, 1);
            rd_chk(8'h02, 8'h00);
        end
        overload_det = 1'b0;
        overheat_det = 1'b0;
        step(4);
        if (latch) begin
            rd_chk(8'h02, 8'h00);
            host.write_burst(8'h02, 32'h0000000A, 1);
            step(3);
        end
        chk("level_sel", 8'h0A, ctl.level_sel);
        chk("output_on", 8'h01, ctl.output_on);
    endtask : fault_case
    // a reset in mid-run wipes the registers again
    task automatic reset_midrun();
        host.write_burst(8'h03, 32'h00000405, 2);
        rd_chk(8'h03, 8'h05);
        rstn = 1'b0;
        step(2);
        rstn = 1'b1;
        step(1);
        reset_values();
    endtask : reset_midrun
    // watchdog against a hung sequence
    initial begin
        #2000000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        step(2);
        rstn = 1'b1;
        step(1);
        reset_values();
        burst_and_map();
        tone_gate();
        for (int m = 0; m < 4; m++) fault_case(m[0], m[1]);
        reset_midrun();
        tally_and_finish();
    end
endmodule : satellite_supply_ctrl_regs_bench
`default_nettype wire
